// *** hw/chan_zero_regs.v ***
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "chan_zero_defs.vh"

// What this block does
// - Read-write three-bit arbitration scheme select.
// - Unsupported scheme selection gives undefined behaviour.
// - Channel identifier reads zero, read-only.
// - Channel enable fixed at one, read-only.
// - Table entry write sets dirty flag.
// - Dirty flag clears after triggered load completes.
// - Dirty flag meaningful only for table schemes.
// - Negotiation pending always reads zero.
// - Load trigger: write one starts, reads zero.
// - Capability advertises only hardware-fixed arbitration.
module chan_zero_regs #(
    parameter [3:0] LOAD_CYCLES = `LOAD_CYCLES
) (
    // Clock and reset.
    input  wire        clock,
    input  wire        resetn,
    // Register port.
    input  wire [11:0] address,
    input  wire [31:0] write_data,
    input  wire        write_strobe,
    input  wire        read_strobe,
    output reg  [31:0] read_data_q,
    // Arbiter side.
    output reg  [2:0]  port_arb_scheme_select_q,
    output reg  [7:0]  tc_map_q,
    output reg         table_load_pulse_q
);

    // Status flag and the loader busy and done outputs, wired straight from the loader.
    reg         arb_table_dirty_flag_q;
    wire        loader_busy;
    wire        loader_done;
    reg         trigger_d;
    reg  [31:0] read_d;

    // True when the address is word-aligned and falls inside the arbitration table window.
    function is_table;
        input [11:0] a;
        begin
            is_table = (a >= `TABLE_BASE_ADDR) && (a <= `TABLE_LAST_ADDR) && (a[1:0] == 2'b00);
        end
    endfunction

    // Assembles the control register image.
    function [31:0] control_image;
        input [2:0] scheme;
        input [7:0] map;
        begin
            control_image = 32'h0;
            control_image[`TC_MAP_MSB:`TC_MAP_LSB] = map;
            control_image[`SCHEME_MSB:`SCHEME_LSB] = scheme;
            control_image[`CHANNEL_ID_MSB:`CHANNEL_ID_LSB] = `CHANNEL_ID_VALUE;
            control_image[`CHANNEL_ENABLE_BIT] = `CHANNEL_ENABLE_VALUE;
            control_image[`LOAD_TRIGGER_BIT] = 1'b0;
        end
    endfunction

    // Decodes a load request from a control write with the trigger bit high.
    always @* begin
        trigger_d = 1'b0;
        if (write_strobe && (address == `CONTROL_ADDR)) begin
            trigger_d = write_data[`LOAD_TRIGGER_BIT];
        end
    end

    // Sequencer that models the table transfer into the arbiter.
    table_loader #(
        .LOAD_CYCLES (LOAD_CYCLES)
    ) loader (
        .clock  (clock),
        .resetn (resetn),
        .start  (trigger_d),
        .busy_q (loader_busy),
        .done_q (loader_done)
    );

    // Writable control fields; the scheme is stored as written, unchecked.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_arb_scheme_select_q <= `SCHEME_RESET;
            tc_map_q                 <= `TC_MAP_RESET;
            table_load_pulse_q       <= 1'b0;
        end else begin
            table_load_pulse_q <= trigger_d && !loader_busy;
            if (write_strobe && (address == `CONTROL_ADDR)) begin
                // Scheme values outside the capability are kept; their effect is undefined.
                port_arb_scheme_select_q <= write_data[`SCHEME_MSB:`SCHEME_LSB];
                // Traffic class 0 stays mapped; its bit is read-only.
                tc_map_q <= {write_data[`TC_MAP_MSB:`TC_MAP_LSB + 1], 1'b1};
            end
        end
    end

    // Dirty flag: a table write sets it, load completion clears, set wins.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arb_table_dirty_flag_q <= 1'b0;
        end else if (write_strobe && is_table(address)) begin
            arb_table_dirty_flag_q <= 1'b1;
        end else if (loader_done) begin
            // Kept regardless of scheme; it only matters for table schemes.
            arb_table_dirty_flag_q <= 1'b0;
        end
    end

    // Read multiplexer; unmapped and reserved bits return zero.
    always @* begin
        read_d = 32'h0;
        if (address == `CAPABILITY_ADDR) begin
            read_d[`CAPABILITY_MSB:`CAPABILITY_LSB] = `CAPABILITY_VALUE;
            read_d[`TABLE_OFFSET_MSB:`TABLE_OFFSET_LSB] = `TABLE_OFFSET_VALUE;
        end else if (address == `CONTROL_ADDR) begin
            read_d = control_image(port_arb_scheme_select_q, tc_map_q);
        end else if (address == `STATUS_ADDR) begin
            read_d[`DIRTY_FLAG_BIT] = arb_table_dirty_flag_q;
            read_d[`NEGOTIATION_BIT] = `NEGOTIATION_VALUE;
        end else begin
            read_d = 32'h0;
        end
    end

    // Read data stand in the cycle after the strobe only.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            read_data_q <= 32'h0;
        end else if (read_strobe) begin
            read_data_q <= read_d;
        end else begin
            read_data_q <= 32'h0;
        end
    end

endmodule // chan_zero_regs

// *** hw/chan_zero_defs.vh ***
`ifndef CHAN_ZERO_DEFS_VH
`define CHAN_ZERO_DEFS_VH

// Register byte addresses.
`define CAPABILITY_ADDR      12'h210
`define CONTROL_ADDR         12'h214
`define STATUS_ADDR          12'h218
`define TABLE_BASE_ADDR      12'h240
`define TABLE_LAST_ADDR      12'h27c

// Control register fields.
`define TC_MAP_LSB           0
`define TC_MAP_MSB           7
`define TC_MAP_RESET         8'hff
`define LOAD_TRIGGER_BIT     16
`define SCHEME_LSB           17
`define SCHEME_MSB           19
`define SCHEME_RESET         3'h0
`define CHANNEL_ID_LSB       24
`define CHANNEL_ID_MSB       26
`define CHANNEL_ID_VALUE     3'h0
`define CHANNEL_ENABLE_BIT   31
`define CHANNEL_ENABLE_VALUE 1'h1

// Status register fields.
`define DIRTY_FLAG_BIT       16
`define NEGOTIATION_BIT      17
`define NEGOTIATION_VALUE    1'h0

// Capability register fields.
`define CAPABILITY_LSB       0
`define CAPABILITY_MSB       7
`define CAPABILITY_VALUE     8'h01
`define TABLE_OFFSET_LSB     24
`define TABLE_OFFSET_MSB     31
`define TABLE_OFFSET_VALUE   8'h04

// Cycles the table transfer into the arbiter takes.
`define LOAD_CYCLES          4'h4

`endif

// *** hw/table_loader.v ***
`timescale 1ns/1ps
`include "chan_zero_defs.vh"

// Sequences the transfer of table values into the arbitration logic.
module table_loader #(
    parameter [3:0] LOAD_CYCLES = `LOAD_CYCLES
) (
    // Clock and reset.
    input  wire       clock,
    input  wire       resetn,
    // Control.
    input  wire       start,
    output reg        busy_q,
    output reg        done_q
);

    // Remaining transfer cycles.
    reg [3:0] count_q;

    // Counts the transfer down and pulses done at its end.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= 4'h0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                // A new load begins; a trigger while busy is ignored and starts no further load.
                count_q <= LOAD_CYCLES;
                busy_q  <= 1'b1;
            end else if (busy_q) begin
                if (count_q == 4'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                count_q <= count_q - 4'h1;
            end
        end
    end

endmodule // table_loader

// *** bench/chan_zero_checker.sv ***
`timescale 1ns/1ps
// Watches the register port and the arbiter outputs.
module chan_zero_checker (
    input wire        clock,
    input wire        resetn,
    input wire [11:0] address,
    input wire [31:0] write_data,
    input wire        write_strobe,
    input wire        read_strobe,
    input wire [31:0] read_data_q,
    input wire [2:0]  port_arb_scheme_select_q,
    input wire [7:0]  tc_map_q,
    input wire        table_load_pulse_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire wc = write_strobe && address == 12'h214;
    wire rc = read_strobe && address == 12'h214;
    wire rs = read_strobe && address == 12'h218;
    property p_sel; wc |=> port_arb_scheme_select_q == $past(write_data[19:17]); endproperty
    a_sel: assert property (p_sel) else $error("scheme");
    property p_fix; rc |=> read_data_q[31:20] == 12'h800 && read_data_q[15:8] == 8'h0; endproperty
    a_fix: assert property (p_fix) else $error("fixed");
    property p_trg; rc |=> !read_data_q[16]; endproperty
    a_trg: assert property (p_trg) else $error("trigger");
    property p_pls; table_load_pulse_q |-> $past(wc && write_data[16]); endproperty
    a_pls: assert property (p_pls) else $error("pulse");
    property p_cap; read_strobe && address == 12'h210 |=> read_data_q[7:0] == 8'h01; endproperty
    a_cap: assert property (p_cap) else $error("cap");
    property p_sts; rs |=> read_data_q[31:17] == 15'h0 && read_data_q[15:0] == 16'h0; endproperty
    a_sts: assert property (p_sts) else $error("status");
    property p_idl; !read_strobe |=> read_data_q == 32'h0; endproperty
    a_idl: assert property (p_idl) else $error("idle");
    property p_dty; write_strobe && address == 12'h240 ##1 rs |=> read_data_q[16]; endproperty
    a_dty: assert property (p_dty) else $error("dirty");
    c_pls: cover property (table_load_pulse_q);
    c_dty: cover property (rs ##1 read_data_q[16]);
    c_sel: cover property (port_arb_scheme_select_q == 3'h7);
endmodule // chan_zero_checker

bind chan_zero_regs chan_zero_checker i_chan_zero_checker (.*);

// *** bench/testbench.sv ***
`timescale 1ns/1ps
// Drives the register port and judges the answers.
module testbench;
    reg         clock = 1'b0;
    reg         resetn = 1'b0;
    reg  [11:0] address = 12'h0;
    reg  [31:0] write_data = 32'h0;
    reg         write_strobe = 1'b0;
    reg         read_strobe = 1'b0;
    wire [31:0] read_data_q;
    wire [2:0]  sel;
    wire [7:0]  tc_map;
    wire        pulse;
    integer     n_errors = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     i;
    always #10 clock = ~clock;
    chan_zero_regs i_chan_zero_regs (.clock(clock), .resetn(resetn), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data_q(read_data_q), .port_arb_scheme_select_q(sel), .tc_map_q(tc_map), .table_load_pulse_q(pulse));
    task chk(input [31:0] seen, input [31:0] exp); begin
        compares = compares + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end endtask
    task test_done; begin
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end endtask
    task wr(input [11:0] a, input [31:0] d); begin
        @(posedge clock); address <= a; write_data <= d; write_strobe <= 1'b1;
        @(posedge clock); write_strobe <= 1'b0; #1;
    end endtask
    task rd(input [11:0] a, input [31:0] exp); begin
        @(posedge clock); address <= a; read_strobe <= 1'b1;
        @(posedge clock); read_strobe <= 1'b0; #1;
        chk(read_data_q, exp);
    end endtask
    // Reset values, capability and an unmapped place.
    task t_reset; begin
        rd(12'h214, 32'h800000ff);
        rd(12'h218, 32'h0);
        rd(12'h210, 32'h04000001);
        rd(12'h300, 32'h0);
    end endtask
    // Every scheme code, with read-only bits written against their value.
    task t_sel; begin
        for (i = 0; i < 8; i = i + 1) begin
            wr(12'h214, 32'h7ff0ff00 | (i << 17));
            chk({29'h0, sel}, i);
            chk({24'h0, tc_map}, 32'h1);
            rd(12'h214, 32'h80000001 | (i << 17));
        end
        // Leave the scheme on the only advertised code before the load test.
        wr(12'h214, 32'h000000fe);
        rd(12'h214, 32'h800000ff);
    end endtask
    // Table write, load trigger and flag clear.
    task t_load; begin
        wr(12'h240, 32'h12345678);
        rd(12'h218, 32'h00010000);
        wr(12'h214, 32'h00010000);
        chk({31'h0, pulse}, 32'h1);
        rd(12'h218, 32'h00010000);
        repeat (4) @(posedge clock);
        rd(12'h218, 32'h0);
        wr(12'h218, 32'hffffffff);
        rd(12'h218, 32'h0);
    end endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        t_reset;
        t_sel;
        t_load;
        test_done;
    end
endmodule // testbench
